// ==== pkg/gpio_port_consts.svh ====
`ifndef GPIO_PORT_CONSTS_SVH
`define GPIO_PORT_CONSTS_SVH

// Word addresses of the registers.
`define ADDR_PIN_LEVEL     4'h0
`define ADDR_OUT_LATCH     4'h1
`define ADDR_DIRECTION     4'h2
`define ADDR_ANALOG_SEL    4'h3
`define ADDR_CMP_CTRL      4'h4
`define ADDR_CONFIG        4'h5
`define ADDR_PERIPH_ENABLE 4'h6

// Reset values.
`define RST_DIRECTION   8'hFF
`define RST_LATCH       8'h00
`define RST_ANALOG_SEL  8'h2F
`define RST_CMP_CTRL    8'h00
`define RST_CONFIG      8'h1F
`define RST_PERIPH_EN   8'h00

// Field positions in the configuration word.
`define CFG_OSC_PINS     0
`define CFG_PWM_ROUTE    1
`define CFG_TIMER_ROUTE  2
`define CFG_CAP3_ROUTE   3
`define CFG_CAP2_ROUTE   4

// Field positions in the peripheral enable word.
`define PEN_SERIAL_CLK   0
`define PEN_PWM_B        1
`define PEN_CAP3         2
`define PEN_CAP2         3

// Comparator output lanes in the comparator control word.
`define CMP1_OUT_EN      0
`define CMP2_OUT_EN      1

// Pin positions of fixed shared functions.
`define PIN_TIMER_CLK    4
`define PIN_CMP1_OUT     4
`define PIN_CMP2_OUT     5
`define PIN_SERIAL_CLK   0
`define PIN_OSC_LO       6
`define PIN_OSC_HI       7
`define PIN_PWM_B_DEF    2
`define PIN_PWM_B_ALT    3
`define PIN_CAP3_DEF     1
`define PIN_CAP3_ALT     5
`define PIN_CAP2_DEF     3
`define PIN_CAP2_ALT     1
`define PIN_TCLK_DEF     4
`define PIN_TCLK_ALT     0

`define OSC_MASK         8'hC0
`define COMPARATOR_MASK  8'h3F

`endif

// ==== pkg/gpio_port_pkg.sv ====
package gpio_port_pkg;
	// Bus slave states along a Gray path.
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ACK  = 2'b01
	} bus_state_t;
endpackage : gpio_port_pkg

// ==== design/pin_slice.sv ====
`timescale 1ns/100ps
`default_nettype none
module pin_slice (
	// Clock and reset.
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Control.
	input  wire logic dir_i,
	input  wire logic latch_i,
	input  wire logic analog_i,
	input  wire logic periph_own_i,
	input  wire logic periph_out_i,
	// Pad.
	input  wire logic pad_i,
	output logic      pad_o,
	output logic      pad_oe_o,
	// Synchronised digital level.
	output logic      level_o
);
	logic sync1_r;
	logic sync1_nxt;
	logic sync2_r;
	logic sync2_nxt;

	// Direction picks the driver; a peripheral takes the data source.
	always_comb begin
		pad_oe_o = ~dir_i;
		pad_o    = periph_own_i ? periph_out_i : latch_i;
	end

	// Analog select blocks the digital input before the synchroniser.
	always_comb begin
		sync1_nxt = pad_i & ~analog_i;
		sync2_nxt = sync1_r;
	end

	// Two flops per pin keep a moving pad from reaching read data.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
		end
	end

	assign level_o = sync2_r;
endmodule : pin_slice
`default_nettype wire

// ==== design/gpio_port.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_consts.svh"
module gpio_port (
	// Clock and reset.
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Wishbone slave.
	input  wire logic       cyc_i,
	input  wire logic       stb_i,
	input  wire logic       we_i,
	input  wire logic [3:0] adr_i,
	input  wire logic [3:0] sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]     dat_o,
	output logic            ack_o,
	// Port pads.
	input  wire logic [7:0] pad_i,
	output logic [7:0]      pad_o,
	output logic [7:0]      pad_oe_o,
	// Peripheral outputs routed onto pins.
	input  wire logic       cmp1_out_i,
	input  wire logic       cmp2_out_i,
	input  wire logic       serial_clk_out_i,
	input  wire logic       pwm_b_out_i,
	input  wire logic       cap3_out_i,
	input  wire logic       cap2_out_i,
	// Peripheral inputs taken from pins.
	output logic            timer_clk_o,
	output logic            serial_clk_in_o,
	output logic            cap3_in_o,
	output logic            cap2_in_o,
	output logic [5:0]      cmp_pins_o
);
	logic [7:0] dir_r;
	logic [7:0] dir_nxt;
	logic [7:0] lat_r;
	logic [7:0] lat_nxt;
	logic [7:0] ans_r;
	logic [7:0] ans_nxt;
	logic [7:0] cmp_r;
	logic [7:0] cmp_nxt;
	logic [7:0] cfg_r;
	logic [7:0] cfg_nxt;
	logic [7:0] pen_r;
	logic [7:0] pen_nxt;
	logic [31:0] rdat_r;
	logic [31:0] rdat_nxt;
	gpio_port_pkg::bus_state_t st_r;
	gpio_port_pkg::bus_state_t st_nxt;
	logic [7:0] level;
	logic [7:0] own;
	logic [7:0] pout;
	logic [7:0] osc_mask;
	logic       wr_en;

	// Byte lane 0 write merge, used by every register.
	function automatic logic [7:0] merge(input logic [7:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge = s[0] ? d[7:0] : old;
	endfunction : merge

	// Oscillator takeover masks bits 6 and 7 out of ownership, drivers and the pin, latch and direction reads.
	assign osc_mask = cfg_r[`CFG_OSC_PINS] ? ~`OSC_MASK : 8'hFF;

	// Ownership and data of enabled peripherals per pin.
	always_comb begin
		own  = 8'h00;
		pout = 8'h00;
		if (cmp_r[`CMP1_OUT_EN]) begin
			own[`PIN_CMP1_OUT]  = 1'b1;
			pout[`PIN_CMP1_OUT] = cmp1_out_i;
		end
		if (cmp_r[`CMP2_OUT_EN]) begin
			own[`PIN_CMP2_OUT]  = 1'b1;
			pout[`PIN_CMP2_OUT] = cmp2_out_i;
		end
		if (pen_r[`PEN_SERIAL_CLK]) begin
			own[`PIN_SERIAL_CLK]  = 1'b1;
			pout[`PIN_SERIAL_CLK] = serial_clk_out_i;
		end
		if (pen_r[`PEN_PWM_B]) begin
			if (cfg_r[`CFG_PWM_ROUTE]) begin
				own[`PIN_PWM_B_DEF]  = 1'b1;
				pout[`PIN_PWM_B_DEF] = pwm_b_out_i;
			end else begin
				own[`PIN_PWM_B_ALT]  = 1'b1;
				pout[`PIN_PWM_B_ALT] = pwm_b_out_i;
			end
		end
		if (pen_r[`PEN_CAP3]) begin
			if (cfg_r[`CFG_CAP3_ROUTE]) begin
				own[`PIN_CAP3_DEF]  = 1'b1;
				pout[`PIN_CAP3_DEF] = cap3_out_i;
			end else begin
				own[`PIN_CAP3_ALT]  = 1'b1;
				pout[`PIN_CAP3_ALT] = cap3_out_i;
			end
		end
		if (pen_r[`PEN_CAP2]) begin
			if (cfg_r[`CFG_CAP2_ROUTE]) begin
				own[`PIN_CAP2_DEF]  = 1'b1;
				pout[`PIN_CAP2_DEF] = cap2_out_i;
			end else begin
				own[`PIN_CAP2_ALT]  = 1'b1;
				pout[`PIN_CAP2_ALT] = cap2_out_i;
			end
		end
		own = own & osc_mask;
	end

	// Peripheral inputs read the synchronised, analog-gated pin levels.
	always_comb begin
		timer_clk_o = cfg_r[`CFG_TIMER_ROUTE] ?
			level[`PIN_TCLK_DEF] : level[`PIN_TCLK_ALT];
		serial_clk_in_o = level[`PIN_SERIAL_CLK];
		cap3_in_o = cfg_r[`CFG_CAP3_ROUTE] ?
			level[`PIN_CAP3_DEF] : level[`PIN_CAP3_ALT];
		cap2_in_o = cfg_r[`CFG_CAP2_ROUTE] ?
			level[`PIN_CAP2_DEF] : level[`PIN_CAP2_ALT];
		cmp_pins_o = 6'(level & `COMPARATOR_MASK);
	end

	// One slice per pin; oscillator pins are released from the driver.
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_slice
			logic oe_raw;
			pin_slice u_slice (
				.clk_i        (clk_i),
				.rst_i        (rst_i),
				.dir_i        (dir_r[g]),
				.latch_i      (lat_r[g]),
				.analog_i     (ans_r[g]),
				.periph_own_i (own[g]),
				.periph_out_i (pout[g]),
				.pad_i        (pad_i[g]),
				.pad_o        (pad_o[g]),
				.pad_oe_o     (oe_raw),
				.level_o      (level[g])
			);
			assign pad_oe_o[g] = oe_raw & osc_mask[g];
		end
	endgenerate

	assign wr_en = cyc_i & stb_i & we_i & (st_r == gpio_port_pkg::BUS_IDLE);

	// Register writes; the pin register address also lands in the latch.
	always_comb begin
		dir_nxt = dir_r;
		lat_nxt = lat_r;
		ans_nxt = ans_r;
		cmp_nxt = cmp_r;
		cfg_nxt = cfg_r;
		pen_nxt = pen_r;
		if (wr_en) begin
			case (adr_i)
				`ADDR_PIN_LEVEL:     lat_nxt = merge(lat_r, dat_i, sel_i);
				`ADDR_OUT_LATCH:     lat_nxt = merge(lat_r, dat_i, sel_i);
				`ADDR_DIRECTION:     dir_nxt = merge(dir_r, dat_i, sel_i);
				`ADDR_ANALOG_SEL:    ans_nxt = merge(ans_r, dat_i, sel_i);
				`ADDR_CMP_CTRL:      cmp_nxt = merge(cmp_r, dat_i, sel_i);
				`ADDR_CONFIG:        cfg_nxt = merge(cfg_r, dat_i, sel_i);
				`ADDR_PERIPH_ENABLE: pen_nxt = merge(pen_r, dat_i, sel_i);
				default: ;
			endcase
		end
	end

	// Read mux; unmapped words read zero and still acknowledge.
	always_comb begin
		rdat_nxt = rdat_r;
		st_nxt   = gpio_port_pkg::BUS_IDLE;
		case (st_r)
			gpio_port_pkg::BUS_IDLE: begin
				if (cyc_i && stb_i) begin
					st_nxt   = gpio_port_pkg::BUS_ACK;
					rdat_nxt = 32'h0000_0000;
					case (adr_i)
						`ADDR_PIN_LEVEL:     rdat_nxt[7:0] = level & osc_mask;
						`ADDR_OUT_LATCH:     rdat_nxt[7:0] = lat_r & osc_mask;
						`ADDR_DIRECTION:     rdat_nxt[7:0] = dir_r & osc_mask;
						`ADDR_ANALOG_SEL:    rdat_nxt[7:0] = ans_r;
						`ADDR_CMP_CTRL:      rdat_nxt[7:0] = cmp_r;
						`ADDR_CONFIG:        rdat_nxt[7:0] = cfg_r;
						`ADDR_PERIPH_ENABLE: rdat_nxt[7:0] = pen_r;
						default:             rdat_nxt = 32'h0000_0000;
					endcase
				end
			end
			gpio_port_pkg::BUS_ACK: st_nxt = gpio_port_pkg::BUS_IDLE;
			default:                st_nxt = gpio_port_pkg::BUS_IDLE;
		endcase
	end

	// State registers; analog defaults make bit 4 a digital input.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir_r  <= `RST_DIRECTION;
			lat_r  <= `RST_LATCH;
			ans_r  <= `RST_ANALOG_SEL;
			cmp_r  <= `RST_CMP_CTRL;
			cfg_r  <= `RST_CONFIG;
			pen_r  <= `RST_PERIPH_EN;
			rdat_r <= 32'h0000_0000;
			st_r   <= gpio_port_pkg::BUS_IDLE;
		end else begin
			dir_r  <= dir_nxt;
			lat_r  <= lat_nxt;
			ans_r  <= ans_nxt;
			cmp_r  <= cmp_nxt;
			cfg_r  <= cfg_nxt;
			pen_r  <= pen_nxt;
			rdat_r <= rdat_nxt;
			st_r   <= st_nxt;
		end
	end

	assign ack_o = (st_r == gpio_port_pkg::BUS_ACK);
	assign dat_o = rdat_r;
endmodule : gpio_port
`default_nettype wire

// ==== verif/ext_pins.sv ====
`timescale 1ns/100ps
`default_nettype none
// Circuit on the far side of the pads: a source that yields to the port.
module ext_pins (
	// Port side.
	input  wire logic [7:0] drv_i,
	input  wire logic [7:0] oe_i,
	// Level the outside source applies.
	input  wire logic [7:0] src_i,
	// Resolved pin level.
	output logic      [7:0] lvl_o
);
	// A driven pin shows the port's value, a released one the source.
	assign lvl_o = (oe_i & drv_i) | (~oe_i & src_i);
endmodule : ext_pins
`default_nettype wire

// ==== verif/gpio_port_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_consts.svh"
module gpio_port_chk (
	// Clock and reset.
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Bus and pad enables.
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [3:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic [7:0]  pad_oe_o
);
	// One clock domain, so clocking and reset are shared.
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not answered next cycle");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	a_dir_drives_oe: assert property (cyc_i && stb_i && we_i && !ack_o
		&& sel_i[0] && adr_i == `ADDR_DIRECTION
		|=> pad_oe_o[5:0] == ~$past(dat_i[5:0]))
		else $error("drivers do not follow direction");
	a_reset_inputs: assert property ($fell(rst_i) |-> pad_oe_o == 8'h00)
		else $error("driver on after reset");
	a_unmapped_zero: assert property (cyc_i && stb_i && !we_i && !ack_o
		&& adr_i > `ADDR_PERIPH_ENABLE |=> dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
		else $error("read data above byte not zero");
	a_data_holds: assert property (!(cyc_i && stb_i && !ack_o)
		|=> $stable(dat_o))
		else $error("read data changed without access");
endmodule : gpio_port_chk
bind gpio_port gpio_port_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.pad_oe_o(pad_oe_o));
`default_nettype wire

// ==== verif/tb_gpio_port.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_consts.svh"
module tb_gpio_port;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i;
	logic [3:0]  adr_i, sel_i;
	logic [31:0] dat_i, dat_o;
	logic        ack_o, tmr_o, ser_o, c3_o, c2_o;
	logic [5:0]  cp_o;
	logic [7:0]  pad_i, pad_o, pad_oe_o, src;
	logic [5:0]  pv;
	int          err_total, check_count;
	int          cyc_n = 0;
	gpio_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pad_i(pad_i),
		.pad_o(pad_o), .pad_oe_o(pad_oe_o), .cmp1_out_i(pv[0]),
		.cmp2_out_i(pv[1]), .serial_clk_out_i(pv[2]), .pwm_b_out_i(pv[3]),
		.cap3_out_i(pv[4]), .cap2_out_i(pv[5]), .timer_clk_o(tmr_o),
		.serial_clk_in_o(ser_o), .cap3_in_o(c3_o), .cap2_in_o(c2_o),
		.cmp_pins_o(cp_o));
	ext_pins i_ext (.drv_i(pad_o), .oe_i(pad_oe_o), .src_i(src), .lvl_o(pad_i));
	// Free running clock.
	initial begin
		clk_i = 1'h0;
		forever #25 clk_i = ~clk_i;
	end
	// A hung handshake ends the run here rather than never.
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 3000) begin
			err_total = err_total + 1;
			summarize();
		end
	end
	task automatic summarize();
		if (err_total == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count = check_count + 1;
		if (g !== e) begin
			err_total = err_total + 1;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Classic cycle: hold until ack is sampled, then release for a cycle.
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		do @(posedge clk_i); while (ack_o !== 1'h1);
		q = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
	endtask : wb
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(1'h1, a, d, q);
	endtask : wr
	task automatic rd(input string nm, input logic [3:0] a, input logic [7:0] e);
		logic [31:0] q;
		wb(1'h0, a, 8'h00, q);
		chk(nm, e, q[7:0]);
	endtask : rd
	// Lets the two-stage input synchroniser catch up.
	task automatic settle();
		repeat (3) @(posedge clk_i);
	endtask : settle
	// Main sequence.
	initial begin
		rst_i = 1'h1;
		cyc_i = 1'h0;
		stb_i = 1'h0;
		we_i = 1'h0;
		adr_i = 4'h0;
		sel_i = 4'hF;
		dat_i = 32'h0;
		src = 8'hFF;
		pv = 6'h00;
		err_total = 0;
		check_count = 0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		rd("dir", `ADDR_DIRECTION, 8'h3F);
		rd("latch", `ADDR_OUT_LATCH, 8'h00);
		rd("analog", `ADDR_ANALOG_SEL, 8'h2F);
		rd("cmp", `ADDR_CMP_CTRL, 8'h00);
		rd("config", `ADDR_CONFIG, 8'h1F);
		rd("periph", `ADDR_PERIPH_ENABLE, 8'h00);
		rd("pins", `ADDR_PIN_LEVEL, 8'h10);
		rd("unmapped", 4'hF, 8'h00);
		wr(`ADDR_PIN_LEVEL, 8'hA5);
		rd("latch", `ADDR_OUT_LATCH, 8'h25);
		rd("pins", `ADDR_PIN_LEVEL, 8'h10);
		wr(`ADDR_CONFIG, 8'h1E);
		rd("latch", `ADDR_OUT_LATCH, 8'hA5);
		wr(`ADDR_DIRECTION, 8'h0F);
		settle();
		chk("oe", 8'hF0, pad_oe_o);
		chk("drive", 8'hA0, pad_o & pad_oe_o);
		rd("pins", `ADDR_PIN_LEVEL, 8'h80);
		// Analog on every pin must leave the drivers alone.
		wr(`ADDR_ANALOG_SEL, 8'hFF);
		settle();
		chk("oe", 8'hF0, pad_oe_o);
		chk("drive", 8'hA0, pad_o & pad_oe_o);
		rd("pins", `ADDR_PIN_LEVEL, 8'h00);
		wr(`ADDR_ANALOG_SEL, 8'h00);
		rd("pins", `ADDR_PIN_LEVEL, 8'hAF);
		wr(`ADDR_CONFIG, 8'h1F);
		settle();
		chk("osc oe", 8'h30, pad_oe_o);
		// Serial clock owns pin 0 against a latch bit of one.
		wr(`ADDR_DIRECTION, 8'hFE);
		wr(`ADDR_PERIPH_ENABLE, 8'h01);
		for (int v = 0; v < 2; v++) begin
			pv[2] <= v[0];
			settle();
			chk("sclk out", {7'h0, v[0]}, {7'h0, pad_o[0]});
		end
		wr(`ADDR_DIRECTION, 8'hFF);
		src <= 8'hFE;
		settle();
		chk("sclk in", 8'h00, {7'h0, ser_o});
		// PWM output on its default and its alternate pin.
		wr(`ADDR_PERIPH_ENABLE, 8'h02);
		wr(`ADDR_DIRECTION, 8'hF3);
		for (int k = 0; k < 2; k++) begin
			wr(`ADDR_CONFIG, k ? 8'h1C : 8'h1E);
			for (int v = 0; v < 2; v++) begin
				pv[3] <= v[0];
				settle();
				chk("pwm pin", {7'h0, v[0]}, {7'h0, pad_o[k ? 3 : 2]});
			end
		end
		// Timer clock from pin 4 by default, from pin 0 when rerouted.
		wr(`ADDR_DIRECTION, 8'hFF);
		src <= 8'hEF;
		wr(`ADDR_CONFIG, 8'h1E);
		settle();
		chk("tclk def", 8'h00, {7'h0, tmr_o});
		wr(`ADDR_CONFIG, 8'h1A);
		settle();
		chk("tclk alt", 8'h01, {7'h0, tmr_o});
		// First comparator output onto pin 4.
		wr(`ADDR_CMP_CTRL, 8'h01);
		wr(`ADDR_DIRECTION, 8'hEF);
		for (int v = 0; v < 2; v++) begin
			pv[0] <= v[0];
			settle();
			chk("cmp1 pin", {7'h0, v[0]}, {7'h0, pad_o[4]});
		end
		// Capture inputs on default and alternate pins, comparator pins.
		src <= 8'hD3;
		settle();
		chk("cmp pins", 8'h13, {2'h0, cp_o});
		chk("cap3 def", 8'h01, {7'h0, c3_o});
		chk("cap2 def", 8'h00, {7'h0, c2_o});
		wr(`ADDR_CONFIG, 8'h02);
		settle();
		chk("cap3 alt", 8'h00, {7'h0, c3_o});
		chk("cap2 alt", 8'h01, {7'h0, c2_o});
		summarize();
	end
endmodule : tb_gpio_port
`default_nettype wire
